/* design/ucc_pkg.sv */
// package: register map, field positions and reset values of the uart control block
package ucc_pkg;
  localparam logic [1:0] ADDR_CTRL_1 = 2'h0;
  localparam logic [1:0] ADDR_CTRL_2 = 2'h1;
  localparam logic [1:0] ADDR_CTRL_3 = 2'h2;
  localparam logic [1:0] ADDR_STATUS = 2'h3;
  // ctrl_1 fields
  localparam int C1_LOOP = 7;
  localparam int C1_UART_ON = 6;
  localparam int C1_TX_POL_FLIP = 5;
  localparam int C1_NINE_BIT = 4;
  localparam int C1_RESUME_ADDR = 3;
  localparam int C1_IDLE_AFTER_STOP = 2;
  localparam int C1_PARITY_ON = 1;
  localparam int C1_PARITY_ODD = 0;
  // ctrl_2 fields
  localparam int C2_TX_EMPTY_IE = 7;
  localparam int C2_TX_DONE_IE = 6;
  localparam int C2_RX_FULL_IE = 5;
  localparam int C2_IDLE_IE = 4;
  localparam int C2_TX_ON = 3;
  localparam int C2_RX_ON = 2;
  localparam int C2_RX_STANDBY = 1;
  localparam int C2_SEND_BREAK = 0;
  // ctrl_3 fields
  localparam int C3_RX_NINTH = 7;
  localparam int C3_TX_NINTH = 6;
  localparam int C3_OVERRUN_IE = 3;
  localparam int C3_NOISE_IE = 2;
  localparam int C3_FRAME_IE = 1;
  localparam int C3_PARITY_IE = 0;
  localparam logic [7:0] CTRL_1_RST = 8'h00;
  localparam logic [7:0] CTRL_2_RST = 8'h00;
  localparam logic [3:0] CTRL_3_IE_RST = 4'h0;
  // frame lengths in bit times
  localparam logic [3:0] FRAME_LEN_8 = 4'ha;
  localparam logic [3:0] FRAME_LEN_9 = 4'hb;
  localparam logic [15:0] BAUD_DIV_DEFAULT = 16'h0044;
  typedef enum logic [2:0] {UCC_IDLE, UCC_PREAMBLE, UCC_DATA, UCC_BREAK, UCC_IDLE_CHAR} ucc_tx_state_t;
endpackage

/* design/ucc_top.sv */
// uart control and configuration block with transmit framing and receive wake logic
//
// Summary of operation
// - tx polarity flip inverts every serial_out bit
// - nine-bit select picks 9-bit, reset 8-bit
// - frames are start, 8/9 bits, one stop
// - address mark or idle line ends standby
// - idle-after-stop bit is stored only, no logic reads it
// - parity in top bit, generated and checked
// - odd parity when set, even when clear
// - tx irq from empty and done, gated
// - rx irq from full flag when enabled
// - rx irq from idle flag when enabled
// - error irq from four flags, each gated
// - enabling tx sends 10/11 ones preamble
// - disabling tx finishes character then idles
// - tx off-on mid-frame queues idle character
// - rx off keeps flags; reset clears enables
// - standby suppresses rx irqs, wake clears it
// - break pulse spanning a char boundary sends one break; held repeats
// - break toggle before preamble replaces preamble
// - rx ninth bit captured or mirrors bit 7
// - tx ninth bit loaded with data word
// - uart off forces empty/done, blocks tx irq
// - address wake sets full; idle wake silent
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
module ucc_top #(
  parameter logic [15:0] BAUD_DIV = ucc_pkg::BAUD_DIV_DEFAULT
) (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  output logic [7:0] RDATA_OUT,
  input wire logic TX_DATA_VALID_IN,
  input wire logic [7:0] TX_DATA_IN,
  output logic TX_DATA_TAKE_OUT,
  output logic TX_EMPTY_FLAG_OUT,
  output logic TX_DONE_FLAG_OUT,
  input wire logic RX_CHAR_IN,
  input wire logic [8:0] RX_WORD_IN,
  input wire logic RX_IDLE_LINE_IN,
  input wire logic RX_FULL_FLAG_IN,
  input wire logic IDLE_FLAG_IN,
  input wire logic OVERRUN_FLAG_IN,
  input wire logic NOISE_FLAG_IN,
  input wire logic FRAME_FAULT_FLAG_IN,
  input wire logic PARITY_ERR_FLAG_IN,
  output logic RX_WAKE_FULL_OUT,
  output logic PARITY_FAULT_OUT,
  output logic RX_ACTIVE_OUT,
  output logic BAUD_RUN_OUT,
  output logic SERIAL_OUT,
  output logic TX_IRQ_OUT,
  output logic RX_IRQ_OUT,
  output logic ERR_IRQ_OUT
);
  logic [7:0] ctrl_1_q;
  logic [7:0] ctrl_2_q;
  logic [3:0] ctrl_3_ie_q;
  logic rx_ninth_q;
  logic tx_ninth_q;
  logic pre_pend_q, pre_req, load_data;
  logic wr_c1, wr_c2, wr_c3;
  logic uart_on, nine_bit, parity_on, parity_odd, tx_on, rx_standby, send_break;
  logic [15:0] baud_cnt_q;
  logic bit_tick;
  ucc_pkg::ucc_tx_state_t st_q;
  logic [3:0] bit_cnt_q;
  logic [10:0] shift_q;
  logic line_q;
  logic tx_empty_q;
  logic idle_pending_q;
  logic tx_on_q;
  logic brk_seen_q;
  logic [3:0] frame_len;
  logic [8:0] tx_word;
  logic tx_par;
  logic [10:0] tx_frame;

  assign wr_c1 = WR_IN && (ADDR_IN == ucc_pkg::ADDR_CTRL_1);
  assign wr_c2 = WR_IN && (ADDR_IN == ucc_pkg::ADDR_CTRL_2);
  assign wr_c3 = WR_IN && (ADDR_IN == ucc_pkg::ADDR_CTRL_3);
  assign uart_on = ctrl_1_q[ucc_pkg::C1_UART_ON];
  assign nine_bit = ctrl_1_q[ucc_pkg::C1_NINE_BIT];
  assign parity_on = ctrl_1_q[ucc_pkg::C1_PARITY_ON];
  assign parity_odd = ctrl_1_q[ucc_pkg::C1_PARITY_ODD];
  assign tx_on = ctrl_2_q[ucc_pkg::C2_TX_ON];
  assign rx_standby = ctrl_2_q[ucc_pkg::C2_RX_STANDBY];
  assign send_break = ctrl_2_q[ucc_pkg::C2_SEND_BREAK];

  assign frame_len = nine_bit ? ucc_pkg::FRAME_LEN_9 : ucc_pkg::FRAME_LEN_8;

  // parity replaces the top data bit
  // odd adds one to the xor
  // ninth bit joins the data word
  always_comb begin
    tx_par = 1'b0;
    tx_word = {tx_ninth_q, TX_DATA_IN};
    if (parity_on && nine_bit) begin
      tx_par = (^TX_DATA_IN) ^ parity_odd;
      tx_word = {tx_par, TX_DATA_IN};
    end else if (parity_on) begin
      tx_par = (^TX_DATA_IN[6:0]) ^ parity_odd;
      tx_word = {1'b1, tx_par, TX_DATA_IN[6:0]};
    end
  end

  // start bit low, data lsb first, stop bit high
  assign tx_frame = nine_bit ? {1'b1, tx_word, 1'b0} : {1'b1, 1'b1, tx_word[7:0], 1'b0};

  // control registers; is software's duty, so writes are taken as given
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_1_q <= ucc_pkg::CTRL_1_RST;
    end else if (wr_c1) begin
      ctrl_1_q <= WDATA_IN;
    end
  end

  // reset clears tx and rx enables
  // wake condition clears standby, set wins over wake
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_2_q <= ucc_pkg::CTRL_2_RST;
    end else if (wr_c2) begin
      ctrl_2_q <= WDATA_IN;
    end else if (rx_standby && RX_ACTIVE_OUT) begin
      // address mark or idle line wakes
      if (ctrl_1_q[ucc_pkg::C1_RESUME_ADDR] ? (RX_CHAR_IN && (nine_bit ? RX_WORD_IN[8] : RX_WORD_IN[7]))
          : RX_IDLE_LINE_IN) begin
        ctrl_2_q[ucc_pkg::C2_RX_STANDBY] <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ctrl_3_ie_q <= ucc_pkg::CTRL_3_IE_RST;
    end else if (wr_c3) begin
      ctrl_3_ie_q <= WDATA_IN[3:0];
    end
  end

  // tx ninth bit kept across reset
  always_ff @(posedge CLOCK_IN) begin
    if (wr_c3) begin
      tx_ninth_q <= WDATA_IN[ucc_pkg::C3_TX_NINTH];
    end
  end

  // capture with data register, mirror bit 7 in 8-bit mode
  always_ff @(posedge CLOCK_IN) begin
    if (RX_CHAR_IN) begin
      rx_ninth_q <= nine_bit ? RX_WORD_IN[8] : RX_WORD_IN[7];
    end
  end

  // check parity on each received character
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      PARITY_FAULT_OUT <= 1'b0;
    end else if (RX_CHAR_IN) begin
      PARITY_FAULT_OUT <= parity_on && ((nine_bit ? (^RX_WORD_IN) : (^RX_WORD_IN[7:0])) != parity_odd);
    end else begin
      PARITY_FAULT_OUT <= 1'b0;
    end
  end

  // address wake reports a full register, idle wake does not
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_WAKE_FULL_OUT <= 1'b0;
    end else begin
      RX_WAKE_FULL_OUT <= RX_CHAR_IN && rx_standby && ctrl_1_q[ucc_pkg::C1_RESUME_ADDR]
                          && (nine_bit ? RX_WORD_IN[8] : RX_WORD_IN[7]);
    end
  end

  // receiver enable (uart on and rx on) passed to the receiver as a level
  // rx off only stops the receiver, flags untouched
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_ACTIVE_OUT <= 1'b0;
    end else begin
      RX_ACTIVE_OUT <= uart_on && ctrl_2_q[ucc_pkg::C2_RX_ON];
    end
  end

  // baud divider stops when uart is off
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      baud_cnt_q <= 16'h0000;
    end else if (!uart_on || baud_cnt_q == BAUD_DIV - 16'h0001) begin
      baud_cnt_q <= 16'h0000;
    end else begin
      baud_cnt_q <= baud_cnt_q + 16'h0001;
    end
  end
  assign bit_tick = uart_on && (baud_cnt_q == BAUD_DIV - 16'h0001);

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      BAUD_RUN_OUT <= 1'b0;
    end else begin
      BAUD_RUN_OUT <= uart_on;
    end
  end

  // tx_on edge history, for preamble and idle queueing
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_on_q <= 1'b0;
    end else begin
      tx_on_q <= tx_on;
    end
  end

  // a break toggle before the preamble is remembered
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      brk_seen_q <= 1'b0;
    end else if (send_break) begin
      brk_seen_q <= 1'b1;
    end else if (st_q != ucc_pkg::UCC_IDLE) begin
      brk_seen_q <= 1'b0;
    end
  end

  // enable edge held until a char boundary
  // ticks rarely meet the edge itself, so it is latched
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      pre_pend_q <= 1'b0;
    end else if (!uart_on || !tx_on || (bit_tick && bit_cnt_q == 4'h0)) begin
      pre_pend_q <= 1'b0;
    end else if (tx_on && !tx_on_q && st_q == ucc_pkg::UCC_IDLE) begin
      pre_pend_q <= 1'b1;
    end
  end
  assign pre_req = pre_pend_q || (tx_on && !tx_on_q && st_q == ucc_pkg::UCC_IDLE);
  assign load_data = bit_tick && bit_cnt_q == 4'h0 && tx_on && !send_break && !pre_req && !idle_pending_q
                     && TX_DATA_VALID_IN;

  // off then on mid-frame queues one idle character
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      idle_pending_q <= 1'b0;
    end else if (tx_on && !tx_on_q && st_q != ucc_pkg::UCC_IDLE) begin
      idle_pending_q <= 1'b1;
    end else if (st_q == ucc_pkg::UCC_IDLE_CHAR) begin
      idle_pending_q <= 1'b0;
    end
  end

  // transmit sequencer; one bit per baud tick
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      st_q <= ucc_pkg::UCC_IDLE;
      bit_cnt_q <= 4'h0;
      shift_q <= 11'h7ff;
      line_q <= 1'b1;
    end else if (!uart_on) begin
      st_q <= ucc_pkg::UCC_IDLE;
      line_q <= 1'b1;
    end else if (bit_tick) begin
      if (bit_cnt_q != 4'h0) begin
        line_q <= shift_q[0];
        shift_q <= {1'b1, shift_q[10:1]};
        bit_cnt_q <= bit_cnt_q - 4'h1;
      end else begin
        unique case (st_q)
          ucc_pkg::UCC_IDLE, ucc_pkg::UCC_PREAMBLE, ucc_pkg::UCC_DATA, ucc_pkg::UCC_BREAK,
          ucc_pkg::UCC_IDLE_CHAR: begin
            line_q <= 1'b1;
            st_q <= ucc_pkg::UCC_IDLE;
            // break while set, back to back with no ones
            if (tx_on && (send_break || (brk_seen_q && pre_req))) begin
              st_q <= ucc_pkg::UCC_BREAK;
              shift_q <= 11'h000;
              line_q <= 1'b0;
              bit_cnt_q <= frame_len - 4'h1;
            // fresh enable sends a preamble of all ones
            end else if (tx_on && pre_req) begin
              st_q <= ucc_pkg::UCC_PREAMBLE;
              shift_q <= 11'h7ff;
              bit_cnt_q <= frame_len - 4'h1;
            end else if (tx_on && idle_pending_q) begin
              st_q <= ucc_pkg::UCC_IDLE_CHAR;
              shift_q <= 11'h7ff;
              bit_cnt_q <= frame_len - 4'h1;
            // no new data once tx is off; line rests high
            end else if (tx_on && TX_DATA_VALID_IN) begin
              st_q <= ucc_pkg::UCC_DATA;
              shift_q <= {1'b1, tx_frame[10:1]};
              line_q <= tx_frame[0];
              bit_cnt_q <= frame_len - 4'h1;
            end
          end
          default: st_q <= ucc_pkg::UCC_IDLE;
        endcase
      end
    end
  end

  // inversion applies to every bit, idle included
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      SERIAL_OUT <= 1'b1;
    end else begin
      SERIAL_OUT <= line_q ^ ctrl_1_q[ucc_pkg::C1_TX_POL_FLIP];
    end
  end

  // data handoff pulse; a take sets empty and wins over a new load
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TX_DATA_TAKE_OUT <= 1'b0;
    end else begin
      TX_DATA_TAKE_OUT <= load_data;
    end
  end

  // uart off forces empty and done high
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      tx_empty_q <= 1'b1;
    end else if (!uart_on || TX_DATA_TAKE_OUT) begin
      tx_empty_q <= 1'b1;
    end else if (TX_DATA_VALID_IN) begin
      tx_empty_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TX_EMPTY_FLAG_OUT <= 1'b1;
      TX_DONE_FLAG_OUT <= 1'b1;
    end else begin
      TX_EMPTY_FLAG_OUT <= tx_empty_q;
      TX_DONE_FLAG_OUT <= !uart_on || (tx_empty_q && st_q == ucc_pkg::UCC_IDLE && bit_cnt_q == 4'h0);
    end
  end

  // tx request gated by its enables
  // and blocked while uart is off
  // each request is an OR of gated flags
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      TX_IRQ_OUT <= 1'b0;
    end else begin
      TX_IRQ_OUT <= uart_on && ((tx_empty_q && ctrl_2_q[ucc_pkg::C2_TX_EMPTY_IE])
                    || (TX_DONE_FLAG_OUT && ctrl_2_q[ucc_pkg::C2_TX_DONE_IE]));
    end
  end

  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RX_IRQ_OUT <= 1'b0;
    end else begin
      RX_IRQ_OUT <= !rx_standby && ((RX_FULL_FLAG_IN && ctrl_2_q[ucc_pkg::C2_RX_FULL_IE])
                    || (IDLE_FLAG_IN && ctrl_2_q[ucc_pkg::C2_IDLE_IE]));
    end
  end

  // four error flags, each with its enable
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      ERR_IRQ_OUT <= 1'b0;
    end else begin
      ERR_IRQ_OUT <= |({OVERRUN_FLAG_IN, NOISE_FLAG_IN, FRAME_FAULT_FLAG_IN, PARITY_ERR_FLAG_IN} & ctrl_3_ie_q);
    end
  end

  // read data one cycle after the strobe; zero in cycles with no read
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      RDATA_OUT <= 8'h00;
    end else if (RD_IN) begin
      unique case (ADDR_IN)
        ucc_pkg::ADDR_CTRL_1: RDATA_OUT <= ctrl_1_q;
        ucc_pkg::ADDR_CTRL_2: RDATA_OUT <= ctrl_2_q;
        ucc_pkg::ADDR_CTRL_3: RDATA_OUT <= {rx_ninth_q, tx_ninth_q, 2'b00, ctrl_3_ie_q};
        ucc_pkg::ADDR_STATUS: RDATA_OUT <= {tx_empty_q, TX_DONE_FLAG_OUT, 3'b000, st_q};
      endcase
    end else begin
      RDATA_OUT <= 8'h00;
    end
  end
endmodule
`default_nettype wire

/* testbench/ucc_checker.sv */
// checker: bus, interrupt and receive-path assertions of the uart control block
`timescale 1ns/1ns
`default_nettype none
module ucc_checker (
  input wire logic CLOCK_IN,
  input wire logic RST_N_IN,
  input wire logic [1:0] ADDR_IN,
  input wire logic [7:0] WDATA_IN,
  input wire logic WR_IN,
  input wire logic RD_IN,
  input wire logic [7:0] RDATA_OUT,
  input wire logic TX_EMPTY_FLAG_OUT,
  input wire logic TX_DONE_FLAG_OUT,
  input wire logic RX_CHAR_IN,
  input wire logic [8:0] RX_WORD_IN,
  input wire logic RX_FULL_FLAG_IN,
  input wire logic NOISE_FLAG_IN,
  input wire logic RX_WAKE_FULL_OUT,
  input wire logic PARITY_FAULT_OUT,
  input wire logic RX_ACTIVE_OUT,
  input wire logic BAUD_RUN_OUT,
  input wire logic TX_IRQ_OUT,
  input wire logic RX_IRQ_OUT,
  input wire logic ERR_IRQ_OUT
);
  logic [7:0] c1_q;
  logic [7:0] c2_q;
  logic [7:0] c3_q;
  logic pe_q;
  logic am_q;
  // shadow of software writes; standby bit only trusted when 0, hardware may clear it
  always_ff @(posedge CLOCK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      c1_q <= 8'h00;
      c2_q <= 8'h00;
      c3_q <= 8'h00;
    end else if (WR_IN) begin
      if (ADDR_IN == 2'h0) c1_q <= WDATA_IN;
      if (ADDR_IN == 2'h1) c2_q <= WDATA_IN;
      if (ADDR_IN == 2'h2) c3_q <= WDATA_IN;
    end
  end
  always_ff @(posedge CLOCK_IN) begin
    pe_q <= (c1_q[4] ? ^RX_WORD_IN : ^RX_WORD_IN[7:0]) ^ c1_q[0];
    am_q <= RX_CHAR_IN && c1_q[3] && (c1_q[4] ? RX_WORD_IN[8] : RX_WORD_IN[7]);
  end
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_off;
    !c1_q[6] [*3];
  endsequence
  sequence s_rx_req;
    (c1_q[6] && c2_q[2] && c2_q[5] && !c2_q[1] && RX_FULL_FLAG_IN) [*3];
  endsequence
  sequence s_mark;
    am_q && c2_q[1] && c2_q[2];
  endsequence
  property p_off;
    s_off |-> TX_EMPTY_FLAG_OUT && TX_DONE_FLAG_OUT && !BAUD_RUN_OUT && !TX_IRQ_OUT;
  endproperty
  a_off: assert property (p_off) else $error("uart off outputs wrong");
  property p_tx_mask;
    (!c2_q[7] && !c2_q[6]) [*3] |-> !TX_IRQ_OUT;
  endproperty
  a_tx_mask: assert property (p_tx_mask) else $error("tx irq while masked");
  property p_rx_req;
    s_rx_req |-> RX_IRQ_OUT;
  endproperty
  a_rx_req: assert property (p_rx_req) else $error("rx irq missing");
  property p_err_mask;
    (c3_q[3:0] == 4'h0) [*3] |-> !ERR_IRQ_OUT;
  endproperty
  a_err_mask: assert property (p_err_mask) else $error("err irq while masked");
  property p_err_req;
    (c1_q[6] && c2_q[2] && !c2_q[1] && c3_q[2] && NOISE_FLAG_IN) [*3] |-> ERR_IRQ_OUT;
  endproperty
  a_err_req: assert property (p_err_req) else $error("err irq missing");
  property p_parity;
    RX_CHAR_IN && c1_q[6] && c2_q[2] && !c2_q[1] && c1_q[1] |=> PARITY_FAULT_OUT == pe_q;
  endproperty
  a_parity: assert property (p_parity) else $error("parity check wrong");
  property p_wake_req;
    s_mark |-> RX_WAKE_FULL_OUT;
  endproperty
  a_wake_req: assert property (p_wake_req) else $error("mark wake missing");
  property p_rd;
    RD_IN && ADDR_IN == 2'h0 |=> RDATA_OUT == $past(c1_q);
  endproperty
  a_rd: assert property (p_rd) else $error("ctrl_1 readback wrong");
  property p_rx_act;
    c1_q[6] && c2_q[2] |=> RX_ACTIVE_OUT;
  endproperty
  a_rx_act: assert property (p_rx_act) else $error("receiver not active");
endmodule
`default_nettype wire

/* testbench/ucc_serial_node.sv */
// partner model: remote serial receiver framing the transmit line
`timescale 1ns/1ns
`default_nettype none
module ucc_serial_node #(
  parameter int DIV = 4
) (
  input wire logic clk_in,
  input wire logic line_in,
  input wire logic inv_in,
  input wire logic nine_in,
  output var logic [9:0] word_out,
  output var int frames_out
);
  logic lvl;
  assign lvl = line_in ^ inv_in;
  // samples on the falling edge, clear of the launching edge
  initial begin
    word_out = 10'h000;
    frames_out = 0;
    forever begin
      @(negedge clk_in);
      // start bit found at its edge; data bits and stop sampled mid-bit
      if (lvl === 1'h0) begin
        repeat (DIV / 2) @(negedge clk_in);
        for (int i = 0; i < (nine_in ? 10 : 9); i++) begin
          repeat (DIV) @(negedge clk_in);
          word_out[i] = lvl;
        end
        frames_out++;
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/tb_top.sv */
// testbench: register, interrupt, framing and receive scenarios of the uart control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  localparam int DIV = 4;
  logic clk, rst_n, wr, rd, tx_v, rx_c, rx_i, full, idle, ovr, noise, frame, perr, inv, nine;
  logic [1:0] addr;
  logic [7:0] wd, td;
  logic [8:0] rx_w;
  logic [9:0] word;
  wire logic [7:0] rdat;
  wire logic take, emp, done, wake, pf, baud, ser, tirq, rirq, eirq;
  int frames, fails, checked;
  ucc_top #(.BAUD_DIV(16'h0004)) dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wd),
    .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdat), .TX_DATA_VALID_IN(tx_v), .TX_DATA_IN(td), .TX_DATA_TAKE_OUT(take),
    .TX_EMPTY_FLAG_OUT(emp), .TX_DONE_FLAG_OUT(done), .RX_CHAR_IN(rx_c), .RX_WORD_IN(rx_w), .RX_IDLE_LINE_IN(rx_i),
    .RX_FULL_FLAG_IN(full), .IDLE_FLAG_IN(idle), .OVERRUN_FLAG_IN(ovr), .NOISE_FLAG_IN(noise),
    .FRAME_FAULT_FLAG_IN(frame), .PARITY_ERR_FLAG_IN(perr), .RX_WAKE_FULL_OUT(wake), .PARITY_FAULT_OUT(pf),
    .RX_ACTIVE_OUT(), .BAUD_RUN_OUT(baud), .SERIAL_OUT(ser), .TX_IRQ_OUT(tirq), .RX_IRQ_OUT(rirq), .ERR_IRQ_OUT(eirq));
  ucc_serial_node #(.DIV(DIV)) node (.clk_in(clk), .line_in(ser), .inv_in(inv), .nine_in(nine),
    .word_out(word), .frames_out(frames));
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
    end
  endtask
  task automatic lim(input int k, input int b);
    if (k >= b) begin
      fails++;
      final_report();
    end
  endtask
  task automatic wrr(input logic [1:0] a, input logic [7:0] d);
    addr <= a;
    wd <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
    @(posedge clk);
  endtask
  task automatic rdc(input logic [1:0] a, input logic [7:0] m, input logic [7:0] e);
    addr <= a;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    #1 chk(rdat & m, e);
    @(posedge clk);
  endtask
  task automatic rxp(input logic [8:0] w, input logic il);
    rx_w <= w;
    rx_c <= ~il;
    rx_i <= il;
    @(posedge clk);
    rx_c <= 1'h0;
    rx_i <= 1'h0;
    #1;
  endtask
  task automatic gap;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic waitf(input int f);
    int k;
    k = 0;
    while (frames == f && k < 4000) begin
      @(posedge clk);
      k++;
    end
    lim(k, 4000);
  endtask
  task automatic t_reset;
    #1 chk({emp, done, baud}, 3'h6);
    rdc(2'h0, 8'hff, 8'h00);
    rdc(2'h1, 8'hff, 8'h00);
    rdc(2'h2, 8'h3f, 8'h00);
  endtask
  task automatic t_regs;
    wrr(2'h0, 8'h7f);
    wrr(2'h3, 8'hff);
    rdc(2'h0, 8'hff, 8'h7f);
    wrr(2'h1, 8'hf2);
    rdc(2'h1, 8'hff, 8'hf2);
    wrr(2'h2, 8'h4f);
    rdc(2'h2, 8'h7f, 8'h4f);
  endtask
  task automatic t_irq;
    wrr(2'h0, 8'h40);
    wrr(2'h1, 8'hf4);
    full <= 1'h1;
    noise <= 1'h1;
    gap();
    chk({tirq, rirq, eirq}, 3'h7);
    wrr(2'h1, 8'h06);
    wrr(2'h2, 8'h40);
    gap();
    chk({tirq, rirq, eirq}, 3'h0);
    full <= 1'h0;
    noise <= 1'h0;
    wrr(2'h1, 8'hc0);
    wrr(2'h0, 8'h00);
    gap();
    chk({tirq, emp, done}, 3'h3);
  endtask
  task automatic t_tx;
    int n, f;
    logic [9:0] mk;
    wrr(2'h0, 8'h60);
    inv <= 1'h1;
    repeat (60) @(posedge clk);
    for (int m = 0; m < 2; m++) begin
      f = frames;
      mk = m ? 10'h3ff : 10'h1ff;
      nine <= m[0];
      td <= 8'ha5;
      tx_v <= 1'h1;
      wrr(2'h2, 8'h40);
      wrr(2'h0, m ? 8'h70 : 8'h60);
      wrr(2'h1, 8'h08);
      n = 1;
      #1;
      while (take !== 1'h1 && n < 300) begin
        @(posedge clk);
        #1;
        n++;
      end
      lim(n, 300);
      tx_v <= 1'h0;
      chk(n >= (10 + m) * DIV && n <= (12 + m) * DIV + 2, 1'h1);
      waitf(f);
      chk(word & mk, 10'h3a5 & mk);
      wrr(2'h1, 8'h00);
      gap();
      chk(ser, 1'h0);
    end
  endtask
  task automatic t_brk;
    int f;
    f = frames;
    wrr(2'h1, 8'h09);
    wrr(2'h1, 8'h08);
    waitf(f);
    chk(word, 10'h000);
    repeat (4 * DIV) @(posedge clk);
    #1 chk(ser, 1'h0);
    wrr(2'h1, 8'h00);
  endtask
  task automatic t_rx;
    wrr(2'h0, 8'h50);
    wrr(2'h1, 8'h04);
    rxp(9'h100, 1'h0);
    rdc(2'h2, 8'h80, 8'h80);
    wrr(2'h0, 8'h40);
    rxp(9'h080, 1'h0);
    rdc(2'h2, 8'h80, 8'h80);
    rxp(9'h100, 1'h0);
    rdc(2'h2, 8'h80, 8'h00);
    wrr(2'h0, 8'h42);
    rxp(9'h001, 1'h0);
    chk(pf, 1'h1);
    wrr(2'h0, 8'h43);
    rxp(9'h001, 1'h0);
    chk(pf, 1'h0);
    wrr(2'h0, 8'h48);
    wrr(2'h1, 8'h06);
    rxp(9'h080, 1'h0);
    chk(wake, 1'h1);
    rdc(2'h1, 8'h02, 8'h00);
    wrr(2'h0, 8'h40);
    wrr(2'h1, 8'h06);
    rxp(9'h000, 1'h1);
    chk(wake, 1'h0);
    rdc(2'h1, 8'h02, 8'h00);
  endtask
  initial begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end
  initial begin
    {rst_n, wr, rd, tx_v, rx_c, rx_i, full, idle, ovr, noise, frame, perr, inv, nine} = 14'h0000;
    addr = 2'h0;
    wd = 8'h00;
    td = 8'h00;
    rx_w = 9'h000;
    fails = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    t_reset();
    t_regs();
    t_irq();
    t_tx();
    t_brk();
    t_rx();
    final_report();
  end
endmodule
bind ucc_top ucc_checker u_chk (.CLOCK_IN(CLOCK_IN), .RST_N_IN(RST_N_IN), .ADDR_IN(ADDR_IN), .WDATA_IN(WDATA_IN),
  .WR_IN(WR_IN), .RD_IN(RD_IN), .RDATA_OUT(RDATA_OUT), .TX_EMPTY_FLAG_OUT(TX_EMPTY_FLAG_OUT),
  .TX_DONE_FLAG_OUT(TX_DONE_FLAG_OUT), .RX_CHAR_IN(RX_CHAR_IN), .RX_WORD_IN(RX_WORD_IN),
  .RX_FULL_FLAG_IN(RX_FULL_FLAG_IN), .NOISE_FLAG_IN(NOISE_FLAG_IN), .RX_WAKE_FULL_OUT(RX_WAKE_FULL_OUT),
  .PARITY_FAULT_OUT(PARITY_FAULT_OUT), .RX_ACTIVE_OUT(RX_ACTIVE_OUT), .BAUD_RUN_OUT(BAUD_RUN_OUT), .TX_IRQ_OUT(TX_IRQ_OUT),
  .RX_IRQ_OUT(RX_IRQ_OUT), .ERR_IRQ_OUT(ERR_IRQ_OUT));
`default_nettype wire
